// >>> hw/ios_bit_unit.sv
// Single-bit modify and test on one I/O byte.
// Assumes set and clear are never both requested.
`timescale 1ns/1ns
`default_nettype none
module ios_bit_unit (
  input wire logic [7:0] byte_i,
  input wire logic [2:0] sel_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic [7:0] byte_o,
  output logic bit_o
);

  // Chosen bit forced, others pass unchanged
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign byte_o[g] = (sel_i == 3'(g)) ? (set_i | (byte_i[g] & ~clr_i)) : byte_i[g];
    end
  endgenerate

  // Tested bit for skip decisions
  assign bit_o = byte_i[sel_i];

endmodule : ios_bit_unit
`default_nettype wire

// >>> hw/ios_pkg.sv
// Constants, field positions and carrier types for the I/O space block.
// Assumes a single 100 MHz clock shared with the CPU core that drives it.
// Notes on behaviour
// - 64 byte I/O locations, read and write.
// - Bit set and clear only below 0x20.
// - Bit test with skip, low range only.
// - Data address equals I/O address plus 0x20.
// - Status flags at 0x3f, read/write, reset zero.
// - No interrupt taken while global enable clear.
// - Interrupt entry clears enable; interrupt return sets.
// - Bit store fills copy flag; load reads it.
// - Sign flag always negative xor overflow.
// - Arithmetic updates half carry and overflow.
// - Results update negative, zero and carry flags.
// - Stack pointer at 0x3d, 8 bits, reset zero.
// - Push decrements by one, pop increments.
// - Call/entry decrement by two, returns increment.
package ios_pkg;

  // Address map
  localparam logic [5:0] IO_ADDR_STATUS = 6'h3f;
  localparam logic [5:0] IO_ADDR_SP = 6'h3d;
  localparam logic [5:0] IO_BIT_LAST = 6'h1f;
  localparam logic [7:0] IO_SPAN = 8'h40;
  localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
  localparam logic [7:0] DATA_SRAM_FIRST = 8'h60;
  localparam logic [7:0] DATA_SRAM_LAST = 8'hdf;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_SP = 8'h00;

  // Status flag positions
  localparam int unsigned FL_I = 7;
  localparam int unsigned FL_T = 6;
  localparam int unsigned FL_H = 5;
  localparam int unsigned FL_S = 4;
  localparam int unsigned FL_V = 3;
  localparam int unsigned FL_N = 2;
  localparam int unsigned FL_Z = 1;
  localparam int unsigned FL_C = 0;

  // Stack pointer steps
  localparam logic [7:0] SP_STEP_BYTE = 8'h01;
  localparam logic [7:0] SP_STEP_ADDR = 8'h02;

  typedef enum logic [2:0] {
    IO_NOP, IO_READ, IO_WRITE, IO_SET, IO_CLR, IO_SKIP_SET, IO_SKIP_CLR
  } ios_io_op_e;

  typedef enum logic [2:0] {
    STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_IRQ_RET
  } ios_stk_op_e;

  // One I/O request from the core
  typedef struct packed {
    ios_io_op_e op;
    logic via_data;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } ios_io_req_s;

  // Answer to an I/O request, one cycle later
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic skip;
  } ios_io_rsp_s;

  // Flag update from the ALU; mask order is h,v,n,z,c
  typedef struct packed {
    logic valid;
    logic [4:0] mask;
    logic [7:0] result;
    logic half;
    logic ovf;
    logic carry;
  } ios_flag_upd_s;

  // Write toward the peripheral locations
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ios_periph_wr_s;

endpackage : ios_pkg

// >>> hw/ios_status_stack.sv
// I/O space decoder with the processor status flags and stack pointer.
// Assumes the core issues at most one I/O request per cycle and that
// peripherals answer reads combinationally with a hit flag.
`timescale 1ns/1ns
`default_nettype none
module ios_status_stack (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic io_req_valid_i,
  input wire ios_pkg::ios_io_req_s io_req_i,
  output ios_pkg::ios_io_rsp_s io_rsp_o,
  input wire ios_pkg::ios_flag_upd_s flag_upd_i,
  input wire logic bit_store_op_i,
  input wire logic bit_store_val_i,
  input wire ios_pkg::ios_stk_op_e stk_op_i,
  input wire logic irq_req_i,
  output logic irq_take_o,
  input wire logic [7:0] periph_rdata_i,
  input wire logic periph_hit_i,
  output ios_pkg::ios_periph_wr_s periph_wr_o,
  output logic [7:0] status_o,
  output logic [7:0] stack_pointer_o
);

  logic [7:0] processor_status_flags_r;
  logic [7:0] processor_status_flags_nxt;
  logic [7:0] stack_pointer_low_r;
  logic [7:0] stack_pointer_low_nxt;
  ios_pkg::ios_io_rsp_s rsp_r;
  ios_pkg::ios_io_rsp_s rsp_nxt;
  ios_pkg::ios_periph_wr_s pwr_r;
  ios_pkg::ios_periph_wr_s pwr_nxt;
  logic irq_take_r;
  logic irq_take_nxt;

  logic [7:0] io_full;
  logic [5:0] io_addr;
  logic in_range;
  logic is_status;
  logic is_sp;
  logic is_low;
  logic [7:0] rd_byte;
  logic [7:0] mod_byte;
  logic test_bit;
  logic bit_set_op;
  logic bit_clear_op;
  logic skip_if_bit_set_op;
  logic skip_if_bit_clear_op;
  logic do_write;
  logic [7:0] wr_byte;

  // Address decode for both access routes
  // Data route below 0x20 reaches the working registers: refused
  always_comb begin
    if (io_req_i.via_data) begin
      io_full = io_req_i.addr - ios_pkg::DATA_IO_OFFSET;
      in_range = (io_req_i.addr >= ios_pkg::DATA_IO_OFFSET) &&
                 (io_req_i.addr < (ios_pkg::DATA_IO_OFFSET + ios_pkg::IO_SPAN));
    end else begin
      io_full = io_req_i.addr;
      in_range = io_req_i.addr < ios_pkg::IO_SPAN;
    end
    io_addr = io_full[5:0];
    is_status = in_range && (io_addr == ios_pkg::IO_ADDR_STATUS);
    is_sp = in_range && (io_addr == ios_pkg::IO_ADDR_SP);
    is_low = in_range && (io_addr <= ios_pkg::IO_BIT_LAST);
  end

  // Read mux; unmapped locations read zero
  // Peripheral data used only with its hit flag
  always_comb begin
    if (is_status) begin
      rd_byte = processor_status_flags_r;
    end else if (is_sp) begin
      rd_byte = stack_pointer_low_r;
    end else if (in_range && periph_hit_i) begin
      rd_byte = periph_rdata_i;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Operation decode; bit operations only act in the low range
  // Bit ops at 0x20 and up are dropped, never widened
  always_comb begin
    bit_set_op = io_req_valid_i && (io_req_i.op == ios_pkg::IO_SET) && is_low;
    bit_clear_op = io_req_valid_i && (io_req_i.op == ios_pkg::IO_CLR) && is_low;
    skip_if_bit_set_op = io_req_valid_i && (io_req_i.op == ios_pkg::IO_SKIP_SET) && is_low;
    skip_if_bit_clear_op = io_req_valid_i && (io_req_i.op == ios_pkg::IO_SKIP_CLR) && is_low;
    do_write = (io_req_valid_i && in_range && (io_req_i.op == ios_pkg::IO_WRITE)) ||
               bit_set_op || bit_clear_op;
    wr_byte = bit_set_op || bit_clear_op ? mod_byte : io_req_i.wdata;
  end

  // Read-modify-write and bit test
  ios_bit_unit u_bit_unit (
    .byte_i(rd_byte),
    .sel_i(io_req_i.bit_sel),
    .set_i(bit_set_op),
    .clr_i(bit_clear_op),
    .byte_o(mod_byte),
    .bit_o(test_bit)
  );

  // Answer and peripheral write, one cycle after the request
  // Write address and data are don't-care while the strobe is low
  always_comb begin
    rsp_nxt.valid = io_req_valid_i && (io_req_i.op != ios_pkg::IO_NOP);
    rsp_nxt.rdata = (io_req_valid_i && (io_req_i.op == ios_pkg::IO_READ)) ? rd_byte : 8'h00;
    rsp_nxt.skip = (skip_if_bit_set_op && test_bit) ||
                   (skip_if_bit_clear_op && !test_bit);
    pwr_nxt.wr = do_write && !is_status && !is_sp && periph_hit_i;
    pwr_nxt.addr = io_addr;
    pwr_nxt.wdata = wr_byte;
  end

  // Status flags: software write, ALU, bit store, interrupt events
  // Take beats a same-cycle return; sign recomputed last
  always_comb begin
    processor_status_flags_nxt = processor_status_flags_r;
    irq_take_nxt = irq_req_i && processor_status_flags_r[ios_pkg::FL_I];
    if (do_write && is_status) begin
      processor_status_flags_nxt = wr_byte;
    end
    if (flag_upd_i.valid) begin
      if (flag_upd_i.mask[4]) begin
        processor_status_flags_nxt[ios_pkg::FL_H] = flag_upd_i.half;
      end
      if (flag_upd_i.mask[3]) begin
        processor_status_flags_nxt[ios_pkg::FL_V] = flag_upd_i.ovf;
      end
      if (flag_upd_i.mask[2]) begin
        processor_status_flags_nxt[ios_pkg::FL_N] = flag_upd_i.result[7];
      end
      if (flag_upd_i.mask[1]) begin
        processor_status_flags_nxt[ios_pkg::FL_Z] = (flag_upd_i.result == 8'h00);
      end
      if (flag_upd_i.mask[0]) begin
        processor_status_flags_nxt[ios_pkg::FL_C] = flag_upd_i.carry;
      end
    end
    if (bit_store_op_i) begin
      processor_status_flags_nxt[ios_pkg::FL_T] = bit_store_val_i;
    end
    if (stk_op_i == ios_pkg::STK_IRQ_RET) begin
      processor_status_flags_nxt[ios_pkg::FL_I] = 1'b1;
    end
    if (irq_take_nxt) begin
      processor_status_flags_nxt[ios_pkg::FL_I] = 1'b0;
    end
    processor_status_flags_nxt[ios_pkg::FL_S] = processor_status_flags_nxt[ios_pkg::FL_N] ^
                                               processor_status_flags_nxt[ios_pkg::FL_V];
  end

  // Stack pointer: software write, then stack steps on top
  // No range check: the pointer wraps modulo 256
  always_comb begin
    stack_pointer_low_nxt = stack_pointer_low_r;
    if (do_write && is_sp) begin
      stack_pointer_low_nxt = wr_byte;
    end
    unique case (stk_op_i)
      ios_pkg::STK_NONE: begin
      end
      ios_pkg::STK_PUSH: begin
        stack_pointer_low_nxt = stack_pointer_low_nxt - ios_pkg::SP_STEP_BYTE;
      end
      ios_pkg::STK_POP: begin
        stack_pointer_low_nxt = stack_pointer_low_nxt + ios_pkg::SP_STEP_BYTE;
      end
      ios_pkg::STK_CALL: begin
        stack_pointer_low_nxt = stack_pointer_low_nxt - ios_pkg::SP_STEP_ADDR;
      end
      ios_pkg::STK_RET, ios_pkg::STK_IRQ_RET: begin
        stack_pointer_low_nxt = stack_pointer_low_nxt + ios_pkg::SP_STEP_ADDR;
      end
      default: begin
      end
    endcase
    if (irq_take_nxt) begin
      stack_pointer_low_nxt = stack_pointer_low_nxt - ios_pkg::SP_STEP_ADDR;
    end
  end

  // Status flags and interrupt accept registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      processor_status_flags_r <= ios_pkg::RST_STATUS;
      irq_take_r <= 1'b0;
    end else begin
      processor_status_flags_r <= processor_status_flags_nxt;
      irq_take_r <= irq_take_nxt;
    end
  end

  // Stack pointer register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stack_pointer_low_r <= ios_pkg::RST_SP;
    end else begin
      stack_pointer_low_r <= stack_pointer_low_nxt;
    end
  end

  // Answer and peripheral write registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_r <= '0;
      pwr_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // Outputs straight from registers
  assign io_rsp_o = rsp_r;
  assign periph_wr_o = pwr_r;
  assign irq_take_o = irq_take_r;
  assign status_o = processor_status_flags_r;
  assign stack_pointer_o = stack_pointer_low_r;

endmodule : ios_status_stack
`default_nettype wire

// >>> sim/ios_periph_model.sv
// Peripheral model: 32 byte registers in the low I/O range.
// Assumes writes arrive one cycle after the request that caused them.
`timescale 1ns/1ns
`default_nettype none
module ios_periph_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire ios_pkg::ios_io_req_s req_i,
  input wire ios_pkg::ios_periph_wr_s wr_i,
  output logic hit_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [32];
  logic [7:0] ia, junk;
  // Decode; unowned reads show a changing pattern
  assign ia = req_i.via_data ? req_i.addr - 8'h20 : req_i.addr;
  assign hit_o = ia < 8'h20;
  assign rdata_o = hit_o ? mem[ia[4:0]] : junk;
  // Store forwarded bytes
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem <= '{default: 8'h00};
      junk <= 8'h5a;
    end else begin
      junk <= junk + 8'h35;
      if (wr_i.wr) mem[wr_i.addr[4:0]] <= wr_i.wdata;
    end
  end
endmodule : ios_periph_model
`default_nettype wire

// >>> sim/ios_props.sv
// Checker on the ports of the I/O space block.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module ios_props (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic io_req_valid_i,
  input wire ios_pkg::ios_io_req_s io_req_i,
  input wire ios_pkg::ios_io_rsp_s io_rsp_o,
  input wire ios_pkg::ios_stk_op_e stk_op_i,
  input wire logic irq_req_i,
  input wire logic irq_take_o,
  input wire logic periph_hit_i,
  input wire ios_pkg::ios_periph_wr_s periph_wr_o,
  input wire logic [7:0] status_o,
  input wire logic [7:0] stack_pointer_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic quiet;
  // No other change to the stack pointer this cycle
  assign quiet = !io_req_valid_i && !(irq_req_i && status_o[7]);
  a_rsp_one_cycle: assert property (
    io_req_valid_i && io_req_i.op != ios_pkg::IO_NOP |=> io_rsp_o.valid)
    else $error("No response after request");
  a_sign_xor: assert property (
    status_o[4] == (status_o[2] ^ status_o[3])) else $error("Sign flag wrong");
  a_irq_gated: assert property (
    !status_o[7] |=> !irq_take_o) else $error("Interrupt taken while disabled");
  a_take_clears: assert property (
    irq_take_o |-> !status_o[7]) else $error("Enable left set on entry");
  a_push_dec: assert property (
    stk_op_i == ios_pkg::STK_PUSH && quiet
    |=> stack_pointer_o == $past(stack_pointer_o) - 8'h01) else $error("Push step");
  a_ret_inc: assert property (
    stk_op_i == ios_pkg::STK_RET && quiet
    |=> stack_pointer_o == $past(stack_pointer_o) + 8'h02) else $error("Return step");
  a_take_entry: assert property (
    stk_op_i == ios_pkg::STK_NONE && quiet == 1'b0 && !io_req_valid_i
    |=> irq_take_o && stack_pointer_o == $past(stack_pointer_o) - 8'h02)
    else $error("Interrupt entry wrong");
  a_wr_needs_hit: assert property (
    periph_wr_o.wr |-> $past(periph_hit_i)) else $error("Write to unowned location");
endmodule : ios_props
bind ios_status_stack ios_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .io_req_valid_i(io_req_valid_i), .io_req_i(io_req_i), .io_rsp_o(io_rsp_o),
  .stk_op_i(stk_op_i), .irq_req_i(irq_req_i), .irq_take_o(irq_take_o),
  .periph_hit_i(periph_hit_i), .periph_wr_o(periph_wr_o), .status_o(status_o),
  .stack_pointer_o(stack_pointer_o));
`default_nettype wire

// >>> sim/tb.sv
// Bench: random cycles on all inputs against a behavioural model.
// Assumes the peripheral model owns I/O locations below 0x20.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk_i = 1'b0, rstn_i = 1'b0, vld = 1'b0, bit_store_op = 1'b0, bv = 1'b0, irq = 1'b0, hit, take;
  logic [7:0] prd, st, spo, sr = 8'h00, sp = 8'h00, pm [32], ia, a;
  ios_pkg::ios_io_req_s req = '0;
  ios_pkg::ios_flag_upd_s fu = '0;
  ios_pkg::ios_stk_op_e stk = ios_pkg::STK_NONE;
  ios_pkg::ios_io_rsp_s rsp;
  ios_pkg::ios_periph_wr_s pwr;
  int err_count = 0, n_checks = 0, d [6] = '{0, -1, 1, -2, 2, 2};
  ios_status_stack i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .io_req_valid_i(vld),
    .io_req_i(req), .io_rsp_o(rsp), .flag_upd_i(fu), .bit_store_op_i(bit_store_op),
    .bit_store_val_i(bv), .stk_op_i(stk), .irq_req_i(irq), .irq_take_o(take),
    .periph_rdata_i(prd), .periph_hit_i(hit), .periph_wr_o(pwr), .status_o(st),
    .stack_pointer_o(spo));
  ios_periph_model i_per (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req), .wr_i(pwr),
    .hit_o(hit), .rdata_o(prd));
  initial forever #5 mclk_i = ~mclk_i;
  // Hang guard
  initial begin
    #(10 * (5 + 4 * 150) * 4); // Four times the planned run
    err_count++;
    give_verdict();
  end
  // Count one comparison and report a mismatch
  task automatic note(input string nm, input logic [22:0] e, input logic [22:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : note
  // Answer to an I/O request
  task automatic chk_rsp(input ios_pkg::ios_io_rsp_s e);
    note("io_rsp_o", 23'(e), 23'(rsp));
  endtask : chk_rsp
  // Peripheral write; address and data only matter with the strobe
  task automatic chk_pwr(input ios_pkg::ios_periph_wr_s e);
    note("periph_wr_o", 23'(e), pwr.wr ? 23'(pwr) : 23'h0);
  endtask : chk_pwr
  // Status flags, stack pointer and interrupt accept
  task automatic chk_regs(input logic [7:0] es, input logic [7:0] ep, input logic et);
    note("regs", 23'({es, ep, et}), 23'({st, spo, take}));
  endtask : chk_regs
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Model the driven cycle, then compare after the edge
  task automatic step();
    logic sk, pw, tk;
    logic [7:0] rd, ob, nb, mk, vv;
    ios_pkg::ios_io_rsp_s er;
    ios_pkg::ios_periph_wr_s ew;
    ia = req.via_data ? req.addr - 8'h20 : req.addr;
    ob = vld && ia < 8'h20 ? pm[ia[4:0]] : 8'h00;
    {rd, nb, sk, pw} = '0;
    tk = irq && sr[7];
    if (vld) case (req.op)
      ios_pkg::IO_NOP: rd = 8'h00;
      ios_pkg::IO_READ: rd = ia == 8'h3f ? sr : ia == 8'h3d ? sp : ob;
      ios_pkg::IO_WRITE: begin
        if (ia == 8'h3f) sr = req.wdata;
        if (ia == 8'h3d) sp = req.wdata;
        nb = req.wdata;
        pw = ia < 8'h20;
      end
      ios_pkg::IO_SET, ios_pkg::IO_CLR: begin
        nb = ob;
        nb[req.bit_sel] = req.op == ios_pkg::IO_SET;
        pw = ia < 8'h20;
      end
      default: sk = ia < 8'h20 && ob[req.bit_sel] == (req.op == ios_pkg::IO_SKIP_SET);
    endcase
    if (pw) pm[ia[4:0]] = nb;
    mk = {2'b0, fu.mask[4], 1'b0, fu.mask[3:0]};
    vv = {2'b0, fu.half, 1'b0, fu.ovf, fu.result[7], fu.result == 8'h00, fu.carry};
    if (fu.valid) sr = sr & ~mk | vv & mk;
    if (bit_store_op) sr[6] = bv;
    sp = sp + 8'(d[stk]);
    if (stk == ios_pkg::STK_IRQ_RET) sr[7] = 1'b1;
    if (tk) {sr[7], sp} = {1'b0, sp - 8'h02};
    sr[4] = sr[2] ^ sr[3];
    er = {vld && req.op != ios_pkg::IO_NOP, rd, sk};
    ew = pw ? {1'b1, ia[5:0], nb} : 15'h0000;
    @(negedge mclk_i);
    chk_rsp(er);
    chk_pwr(ew);
    chk_regs(sr, sp, tk);
  endtask : step
  // Phases: I/O, flags, stack and interrupts, all mixed
  initial begin
    pm = '{default: 8'h00};
    a = 8'($urandom(53073));
    repeat (5) @(negedge mclk_i);
    rstn_i = 1;
    chk_regs(ios_pkg::RST_STATUS, ios_pkg::RST_SP, 1'b0);
    for (int t = 0; t < 4; t++) begin
      for (int i = 0; i < 150; i++) begin
        {req, fu, bit_store_op, bv} = 42'({$urandom, $urandom});
        a = $urandom % 4 == 0 ? {6'h0f, 1'($urandom), 1'b1} : 8'($urandom % 80);
        req.addr = req.via_data ? a + 8'h20 : a;
        req.op = ios_pkg::ios_io_op_e'(3'($urandom % 7));
        // Every other cycle, so forwarded writes land before reuse
        vld = (t == 0 || t == 3) && i % 2 == 1;
        fu.valid &= 1'(t % 2);
        bit_store_op &= 1'(t % 2);
        stk = ios_pkg::ios_stk_op_e'(3'(t > 1 ? $urandom % 6 : 0));
        irq = t > 1 && $urandom % 3 == 0;
        if (t == 2 && i == 0) begin
          vld = 1'b1;
          irq = 1'b0;
          stk = ios_pkg::STK_NONE;
          {req.via_data, req.addr, req.wdata} = {1'b0, 8'h3d, 8'hdf};
          req.op = ios_pkg::IO_WRITE;
        end
        step();
      end
      $display("Test %0d done", t);
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
